/* verilog/ptm_defines.svh */
// Purpose: offsets, field positions, reset values of the periodic timer
// Assumes: apb byte addresses, one 32-bit word per register
// Notes:   definitions only
`ifndef PTM_DEFINES_SVH
`define PTM_DEFINES_SVH
// ==========================================================
// register offsets
`define PTM_OFS_CTRL0   8'h00
`define PTM_OFS_CTRL1   8'h04
`define PTM_OFS_CNT_LO  8'h08
`define PTM_OFS_CNT_HI  8'h0c
`define PTM_OFS_CMPA_LO 8'h10
`define PTM_OFS_CMPA_HI 8'h14
`define PTM_OFS_PER_LO  8'h18
`define PTM_OFS_PER_HI  8'h1c
`define PTM_OFS_FLAGS   8'h20
// ==========================================================
// control 0 fields
`define PTM_C0_RUN      0
`define PTM_C0_DIV_LSB  4
`define PTM_C0_DIV_MSB  6
// ==========================================================
// control 1 fields
`define PTM_C1_MODE_MSB 7
`define PTM_C1_MODE_LSB 6
`define PTM_C1_IO_MSB   5
`define PTM_C1_IO_LSB   4
`define PTM_C1_OCL      3
`define PTM_C1_POL      2
`define PTM_C1_CCL      0
// ==========================================================
// flag fields and reset values
`define PTM_FLG_A       0
`define PTM_FLG_P       1
`define PTM_RST_BYTE    8'h00
`define PTM_RST_CNT     10'h000
`define PTM_CNT_MAX     10'h3ff
`endif

/* verilog/ptm_pkg.sv */
// Purpose: types shared by the periodic timer files
// Assumes: nothing
// Notes:   mode codes follow declaration order
package ptm_pkg;
  // ==========================================================
  // operating mode, codes 00 01 10 11 in this order
  typedef enum logic [1:0] {
    PTM_MODE_CMP,
    PTM_MODE_CAPT,
    PTM_MODE_PWM,
    PTM_MODE_TMR
  } ptm_mode_e;

  // ==========================================================
  // control word carried to the output stage
  typedef struct packed {
    ptm_mode_e  mode;
    logic [1:0] io;
    logic       ocl;
    logic       pol;
    logic       ccl;
  } ptm_ctrl_s;
endpackage : ptm_pkg

/* verilog/ptm_prescale.sv */
// Purpose: timer clock enable from the system clock
// Assumes: 50 MHz clk
// Notes:   divides by 2 to the power of sel
`timescale 1ns/1ps
module ptm_prescale import ptm_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] sel,
  output logic            tick
);
  // ==========================================================
  // free divider
  logic [6:0] div_r;
  logic [6:0] mask;

  // a zero select gives an empty mask, so every clk is a tick
  assign mask = (7'h01 << sel) - 7'h01;
  assign tick = ((div_r & mask) == mask);

  always_ff @(posedge clk) begin
    if (!rst_n) div_r <= 7'h00;
    else        div_r <= div_r + 7'h01;
  end
endmodule : ptm_prescale

/* verilog/ptm_out.sv */
// Purpose: output pin stage of the periodic timer
// Assumes: events arrive as one-cycle pulses on clk
// Notes:   pin level and enable come from flip-flops
`timescale 1ns/1ps
module ptm_out import ptm_pkg::*; (
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire ptm_ctrl_s ctrl,
  input  wire logic      run_rise,
  input  wire logic      a_event,
  input  wire logic      pwm_active,
  output logic           pin_out,
  output logic           pin_oe
);
  // ==========================================================
  // compare state and pin selection
  logic cmp_r;
  logic cmp_nxt;
  logic pwm_lvl;
  logic pin_nxt;

  assign cmp_nxt = run_rise ? ctrl.ocl :
                   !a_event ? cmp_r :
                   (ctrl.io == 2'h1) ? 1'b0 :
                   (ctrl.io == 2'h2) ? 1'b1 :
                   (ctrl.io == 2'h3) ? ~cmp_r : cmp_r;

  // active level from ocl; io forces inactive, active, or waveform
  assign pwm_lvl = (ctrl.io == 2'h0) ? ~ctrl.ocl :
                   (ctrl.io == 2'h1) ? ctrl.ocl :
                   (pwm_active ? ctrl.ocl : ~ctrl.ocl);

  assign pin_nxt = ((ctrl.mode == PTM_MODE_PWM) ? pwm_lvl : cmp_r) ^ ctrl.pol;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmp_r   <= 1'b0;
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      cmp_r   <= cmp_nxt;
      pin_out <= pin_nxt;
      // timer mode releases the pin for other uses
      pin_oe  <= (ctrl.mode == PTM_MODE_CMP) ||
                 (ctrl.mode == PTM_MODE_PWM && ctrl.io != 2'h3);
    end
  end
endmodule : ptm_out

/* verilog/ptm_top.sv */
// Purpose: periodic timer with compare, timer and pwm modes, apb slave
// Assumes: 50 MHz clk, synchronous active-low reset
// Notes:   counter advances on the prescaler enable only
//
// Overview of operation
// - mode field 00 selects compare match output mode.
// - mode 11 counts like compare mode but leaves the pin unused.
// - mode 10 with output select not 11 selects pwm output mode.
// - compare, clear-select low: clear on period match or overflow; both flags.
// - compare, clear-select high: clear on compare a; only the a flag.
// - compare a value zero, clear-select high: counter overflows at 3ff, no a flag.
// - compare mode output changes only on a compare a flag event or a run bit rising edge.
// - compare a event drives high, low or toggles; select zero holds.
// - run bit rising edge loads the output with its initial level.
// - pwm ignores clear-select; period match clears, compare a sets duty.
// - pwm raises a flag and period flag on each of their matches.
// - pwm period equals period value, or 1024 when it is zero.
// - pwm output fully active when compare a reaches the period.
// - pwm output select enables waveform or forces a level; counting continues.
// - pwm active level from initial-level bit, pin inverted by polarity bit.
// - period high byte holds bits 9..8 in bits 1..0, rest zero.
// - pwm initial-level bit 0 is active low, 1 active high.
`timescale 1ns/1ps
`include "ptm_defines.svh"
module ptm_top import ptm_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             pin_out,
  output logic             pin_oe
);
  // ==========================================================
  // register storage
  logic [7:0] ctrl0_r;
  logic [7:0] ctrl1_r;
  logic [7:0] cmpa_lo_r;
  logic [1:0] cmpa_hi_r;
  logic [7:0] per_lo_r;
  logic [1:0] per_hi_r;
  logic [1:0] flag_r;
  logic [9:0] cnt_r;
  logic       run_d_r;

  // ==========================================================
  // address decode
  function automatic logic hit(input logic [31:0] a, input logic [7:0] ofs);
    hit = (a[31:8] == 24'h000000) && (a[7:0] == ofs);
  endfunction : hit

  logic       acc;
  logic       wr;
  logic       mapped;
  logic [7:0] rsel;

  assign acc    = psel & penable;
  assign wr     = acc & pwrite;
  assign mapped = hit(paddr, `PTM_OFS_CTRL0)   | hit(paddr, `PTM_OFS_CTRL1)  |
                  hit(paddr, `PTM_OFS_CNT_LO)  | hit(paddr, `PTM_OFS_CNT_HI) |
                  hit(paddr, `PTM_OFS_CMPA_LO) | hit(paddr, `PTM_OFS_CMPA_HI) |
                  hit(paddr, `PTM_OFS_PER_LO)  | hit(paddr, `PTM_OFS_PER_HI) |
                  hit(paddr, `PTM_OFS_FLAGS);
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // ==========================================================
  // control fields
  ptm_ctrl_s  ctrl;
  logic       run;
  logic [2:0] div_sel;
  logic [9:0] compare_a_value;
  logic [9:0] period_value;

  // one driver for the whole control word
  assign ctrl = '{mode: ptm_mode_e'(ctrl1_r[`PTM_C1_MODE_MSB:`PTM_C1_MODE_LSB]),
                  io:   ctrl1_r[`PTM_C1_IO_MSB:`PTM_C1_IO_LSB],
                  ocl:  ctrl1_r[`PTM_C1_OCL],
                  pol:  ctrl1_r[`PTM_C1_POL],
                  ccl:  ctrl1_r[`PTM_C1_CCL]};
  assign run       = ctrl0_r[`PTM_C0_RUN];
  assign div_sel   = ctrl0_r[`PTM_C0_DIV_MSB:`PTM_C0_DIV_LSB];
  assign compare_a_value      = {cmpa_hi_r, cmpa_lo_r};
  assign period_value      = {per_hi_r, per_lo_r};

  // ==========================================================
  // timer clock and counter compares
  logic        tick;
  logic        step;
  logic        is_pwm;
  logic [10:0] cnt_inc;
  logic [10:0] per_ext;
  logic        p_match;
  logic        a_match;
  logic        clr_on_a;
  logic        clr_cnt;
  logic        a_event;
  logic        p_event;
  logic        pwm_active;
  logic        run_rise;

  ptm_prescale u_pre (
    .clk   (clk),
    .rst_n (rst_n),
    .sel   (div_sel),
    .tick  (tick)
  );

  assign step    = run & tick;
  assign is_pwm  = (ctrl.mode == PTM_MODE_PWM);
  assign cnt_inc = {1'b0, cnt_r} + 11'h001;
  // a zero period stands for the full 1024-count span
  assign per_ext = (period_value == 10'h000) ? 11'h400 : {1'b0, period_value};
  assign p_match = (cnt_inc == per_ext);
  // compare a zero never matches, so with clear on compare a the counter overflows at 3ff
  assign a_match = (compare_a_value != 10'h000) && (cnt_inc == {1'b0, compare_a_value});
  // clear-select only matters outside pwm
  assign clr_on_a = ctrl.ccl & ~is_pwm;
  assign clr_cnt  = clr_on_a ? a_match : p_match;
  assign a_event  = step & a_match;
  assign p_event  = step & p_match & ~clr_on_a;
  // at or above the period the waveform never goes inactive
  assign pwm_active = ({1'b0, compare_a_value} >= per_ext) || (cnt_r < compare_a_value);
  assign run_rise   = run & ~run_d_r;

  always_ff @(posedge clk) begin
    if (!rst_n)       cnt_r <= `PTM_RST_CNT;
    else if (step)    cnt_r <= clr_cnt ? `PTM_RST_CNT : cnt_inc[9:0];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) run_d_r <= 1'b0;
    else        run_d_r <= run;
  end

  // ==========================================================
  // sticky flags, hardware set wins over a write-one clear
  logic [1:0] flag_set;
  logic [1:0] flag_clr;

  assign flag_set = {p_event, a_event};
  assign flag_clr = (wr && hit(paddr, `PTM_OFS_FLAGS)) ? pwdata[1:0] : 2'h0;

  generate
    for (genvar i = 0; i < 2; i++) begin : g_flag
      always_ff @(posedge clk) begin
        if (!rst_n)           flag_r[i] <= 1'b0;
        else if (flag_set[i]) flag_r[i] <= 1'b1;
        else if (flag_clr[i]) flag_r[i] <= 1'b0;
      end
    end
  endgenerate

  // ==========================================================
  // register writes, taken in the access phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl0_r   <= `PTM_RST_BYTE;
      ctrl1_r   <= `PTM_RST_BYTE;
      cmpa_lo_r <= `PTM_RST_BYTE;
      cmpa_hi_r <= 2'h0;
      per_lo_r  <= `PTM_RST_BYTE;
      per_hi_r  <= 2'h0;
    end else if (wr) begin
      if (hit(paddr, `PTM_OFS_CTRL0))   ctrl0_r   <= pwdata[7:0];
      if (hit(paddr, `PTM_OFS_CTRL1))   ctrl1_r   <= pwdata[7:0];
      if (hit(paddr, `PTM_OFS_CMPA_LO)) cmpa_lo_r <= pwdata[7:0];
      if (hit(paddr, `PTM_OFS_CMPA_HI)) cmpa_hi_r <= pwdata[1:0];
      if (hit(paddr, `PTM_OFS_PER_LO))  per_lo_r  <= pwdata[7:0];
      if (hit(paddr, `PTM_OFS_PER_HI))  per_hi_r  <= pwdata[1:0];
    end
  end

  // ==========================================================
  // read data, latched in the setup phase
  logic [7:0] rd_byte;

  assign rd_byte =
    hit(paddr, `PTM_OFS_CTRL0)   ? ctrl0_r :
    hit(paddr, `PTM_OFS_CTRL1)   ? ctrl1_r :
    hit(paddr, `PTM_OFS_CNT_LO)  ? cnt_r[7:0] :
    hit(paddr, `PTM_OFS_CNT_HI)  ? {6'h00, cnt_r[9:8]} :
    hit(paddr, `PTM_OFS_CMPA_LO) ? cmpa_lo_r :
    hit(paddr, `PTM_OFS_CMPA_HI) ? {6'h00, cmpa_hi_r} :
    hit(paddr, `PTM_OFS_PER_LO)  ? per_lo_r :
    hit(paddr, `PTM_OFS_PER_HI)  ? {6'h00, per_hi_r} :
    hit(paddr, `PTM_OFS_FLAGS)   ? {6'h00, flag_r} : 8'h00;

  always_ff @(posedge clk) begin
    if (!rst_n)                 prdata <= 32'h00000000;
    else if (psel && !penable)  prdata <= {24'h000000, rd_byte};
  end

  // ==========================================================
  // output stage
  ptm_out u_out (
    .clk        (clk),
    .rst_n      (rst_n),
    .ctrl       (ctrl),
    .run_rise   (run_rise),
    .a_event    (a_event & ~is_pwm),
    .pwm_active (pwm_active),
    .pin_out    (pin_out),
    .pin_oe     (pin_oe)
  );
endmodule : ptm_top

/* verif/ptm_top_chk.sv */
// Purpose: port-level checks of the periodic timer
// Assumes: ctrl0 at 0x00 (run bit 0), ctrl1 at 0x04, zero-wait apb
// Notes:   control words are shadowed from apb writes
`timescale 1ns/1ps
module ptm_top_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pin_out,
  input wire logic        pin_oe
);
  // ==========================================================
  // shadow registers; delayed copy because the pin stage is registered
  logic [7:0] c1_r;
  logic [7:0] c1_d_r;
  logic       run_r;
  logic       v_r;
  wire        acc_w = psel & penable;
  wire        wr_w  = acc_w & pwrite;
  wire        bad_w = (paddr > 32'h20) || (paddr[1:0] != 2'b00);
  wire        rise_w = wr_w && paddr == 32'h0 && pwdata[0] && !run_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      c1_r   <= 8'h00;
      c1_d_r <= 8'h00;
      run_r  <= 1'b0;
      v_r    <= 1'b0;
    end else begin
      if (wr_w && paddr == 32'h4) c1_r <= pwdata[7:0];
      if (wr_w && paddr == 32'h0) run_r <= pwdata[0];
      c1_d_r <= c1_r;
      v_r    <= 1'b1;
    end
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  oe_cmp_a: assert property (v_r && c1_d_r[7:6] == 2'b00 |-> pin_oe)
    else $error("pin not driven in compare mode");
  oe_tmr_a: assert property (v_r && c1_d_r[7:6] == 2'b11 |-> !pin_oe)
    else $error("pin driven in timer mode");
  oe_pwm_a: assert property (v_r && c1_d_r[7:6] == 2'b10 |->
                            pin_oe == (c1_d_r[5:4] != 2'b11))
    else $error("pin enable wrong in pwm mode");
  run_init_a: assert property (rise_w && c1_r[7:6] == 2'b00 |->
                              ##[1:3] pin_out == (c1_r[3] ^ c1_r[2]))
    else $error("pin not set to initial level on run start");
  hi_zero_a: assert property (acc_w && !pwrite && (paddr == 32'h1c || paddr == 32'h0c) |->
                             prdata[31:2] == 30'h0)
    else $error("high byte unused bits not zero");
  bad_addr_a: assert property (acc_w && bad_w |-> pslverr)
    else $error("no error on unmapped address");
  good_addr_a: assert property (acc_w && !bad_w |-> !pslverr)
    else $error("error on mapped address");
  ready_a: assert property (acc_w |-> pready)
    else $error("ready low in access phase");
  run_c: cover property (rise_w);
  pwm_c: cover property (v_r && c1_d_r[7:6] == 2'b10 && pin_oe);
  err_c: cover property (acc_w && pslverr);
endmodule : ptm_top_chk

bind ptm_top ptm_top_chk u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe));

/* verif/ptm_top_tb.sv */
// Purpose: self-checking bench of the periodic timer
// Assumes: prescale 0, so the counter steps every clk
// Notes:   pwm duty is judged over four whole periods after settling, one period for the zero period case
`timescale 1ns/1ps
`include "ptm_defines.svh"
module ptm_top_tb import ptm_pkg::*;;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, pin_out, pin_oe, err, last;
  logic [31:0] paddr, pwdata, prdata, rdata, s;
  logic [7:0]  c1;
  int          n_mismatch, checked, ch, hi, p, a, act;
  ptm_top u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_out(pin_out), .pin_oe(pin_oe));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================================
  // tasks and model
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {24'h0, ad};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdata = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      n_mismatch++;
      close_out();
    end
  endtask : apb
  task automatic cfg(input logic [7:0] c, input int ca, input int cp);
    apb(1'b1, `PTM_OFS_FLAGS, 32'h3);
    apb(1'b1, `PTM_OFS_CMPA_LO, 32'(ca & 255));
    apb(1'b1, `PTM_OFS_CMPA_HI, 32'(ca >> 8));
    apb(1'b1, `PTM_OFS_PER_LO, 32'(cp & 255));
    apb(1'b1, `PTM_OFS_PER_HI, 32'(cp >> 8));
    apb(1'b1, `PTM_OFS_CTRL1, {24'h0, c});
  endtask : cfg
  // runs n cycles, counts pin changes and high cycles in the last w
  task automatic run(input int n, input int w);
    apb(1'b1, `PTM_OFS_CTRL0, 32'h1);
    ch = 0;
    hi = 0;
    last = pin_out;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (pin_out !== last) ch++;
      if (i >= n - w && pin_out === 1'b1) hi++;
      last = pin_out;
    end
    apb(1'b1, `PTM_OFS_CTRL0, 32'h0);
    apb(1'b0, `PTM_OFS_FLAGS, 32'h0);
  endtask : run
  // expected flags: bit0 compare a, bit1 period
  function automatic logic [31:0] mflag(input int ccl, input int ca);
    return {30'h0, ccl == 0, ca != 0};
  endfunction : mflag
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // ==========================================================
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rst_n} = '0;
    n_mismatch = 0;
    checked = 0;
    s = 32'h4b54;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      apb(1'b0, 8'(k * 4), 32'h0);
      chk("reset value", 32'h0, rdata);
    end
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, `PTM_OFS_PER_HI, 32'hff);
    apb(1'b0, `PTM_OFS_PER_HI, 32'h0);
    chk("period high byte", 32'h3, rdata);
    // compare mode; initial level opposite to the level selects 1 and 2 drive, high for 0 and 3
    for (int io = 0; io < 4; io++) begin
      cfg({2'b00, 2'(io), io != 2, 3'b000}, 2, 4);
      run(40, 0);
      chk("compare flags", mflag(0, 2), rdata);
      if (io == 3) chk("toggle seen", 32'h1, 32'(ch > 2));
      else chk("compare pin", 32'(io != 1), {31'h0, pin_out});
      apb(1'b0, `PTM_OFS_CNT_LO, 32'h0);
      chk("count below period", 32'h1, 32'(rdata < 4));
    end
    cfg(8'h01, 3, 2);
    // long runs: the counter keeps its old value and may first have to wrap
    run(1100, 0);
    chk("clear on a flags", mflag(1, 3), rdata);
    cfg(8'h01, 0, 0);
    run(1100, 0);
    chk("zero a flags", mflag(1, 0), rdata);
    apb(1'b0, `PTM_OFS_CNT_HI, 32'h0);
    chk("count wrapped", 32'h0, rdata);
    cfg(8'he0, 2, 4);
    run(1100, 0);
    chk("timer mode flags", mflag(0, 2), rdata);
    // pwm with random period, duty, select, level and polarity; clear-select set
    for (int k = 0; k < 6; k++) begin
      s = lfsr(s);
      p = 2 + int'(s[3:0]) % 14;
      a = 1 + int'(s[11:4]) % (p + 1);
      c1 = {2'b10, 2'(int'(s[13:12]) % 3), s[14], s[15], 2'b01};
      cfg(c1, a, p);
      run(1100 + 4 * p, 4 * p);
      act = c1[5:4] == 2'b00 ? 0 : c1[5:4] == 2'b01 ? 4 * p : 4 * (a < p ? a : p);
      chk("pwm high cycles", 32'(c1[3] ^ c1[2] ? act : 4 * p - act), 32'(hi));
      if (a < p) chk("pwm flags", mflag(0, a), rdata);
    end
    // zero period gives a 1024-count span; duty 256, active high waveform
    cfg(8'ha8, 256, 0);
    run(2200, 1024);
    chk("pwm zero period high cycles", 32'd256, 32'(hi));
    chk("pwm zero period flags", mflag(0, 256), rdata);
    close_out();
  end
endmodule : ptm_top_tb
